// >>> pkg/psb_pkg.sv
// Purpose: Constants and types for the power-down and interrupt sideband controller
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   Offsets are byte addresses
package psb_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_VECTOR = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0c;

  // Control register fields
  localparam int CTRL_IRQ_GO   = 0;
  localparam int CTRL_AUTO_ACK = 1;
  localparam int CTRL_SW_ACK   = 2;

  // Clear register fields
  localparam int CLR_PENDING = 0;
  localparam int CLR_REFUSED = 1;

  // Status register fields
  localparam int ST_MSI_EN    = 0;
  localparam int ST_MSIX_EN   = 1;
  localparam int ST_INTX_EN   = 2;
  localparam int ST_PD_SEEN   = 3;
  localparam int ST_COMMITTED = 4;
  localparam int ST_IRQ_BUSY  = 5;
  localparam int ST_PENDING   = 6;
  localparam int ST_REFUSED   = 7;
  localparam int ST_REQ_ALLOW = 8;
  localparam int ST_PSTATE_LO = 12;

  // Reset values
  localparam logic       AUTO_ACK_RST = 1'b0;
  localparam logic [4:0] VECTOR_RST   = 5'h00;
  localparam logic [2:0] PSTATE_D0    = 3'h0;

  // Interrupt sequencer states
  typedef enum logic [4:0] {
    IRQ_IDLE   = 5'b00001,
    IRQ_ASSERT = 5'b00010,
    IRQ_DROP   = 5'b00100,
    IRQ_MSI    = 5'b01000,
    IRQ_DONE   = 5'b10000
  } psb_irq_state_type;

endpackage

// >>> hdl/psb_pwr_hs.sv
// Purpose: Power-down acknowledge handshake toward the endpoint core
// Assumes: All inputs synchronous to hclk
// Notes:   Acknowledge is sticky until reset; user logic is then powered off
`timescale 1ns/1ps
module psb_pwr_hs (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Core side
  input  wire logic turn_off_notice,
  output logic      pwr_down_ack,
  // User side
  input  wire logic pkt_busy,
  input  wire logic auto_ack,
  input  wire logic sw_ack,
  output logic      pd_seen,
  output logic      stop_new
);

  typedef struct packed {
    logic ack;
    logic seen;
    logic stop;
    logic sw_ok;
  } psb_pwr_type;

  psb_pwr_type st_r;
  psb_pwr_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (turn_off_notice) begin
      st_nxt.seen = 1'b1;
      st_nxt.stop = 1'b1;
    end
    if (sw_ack) begin
      st_nxt.sw_ok = 1'b1;
    end
    // Ack only once the packet in flight is done and auto_ack is on or software agrees
    if (turn_off_notice && !pkt_busy && (auto_ack || st_r.sw_ok)) begin
      st_nxt.ack = 1'b1;
    end
    // Committed: no way back to traffic short of reset
    if (st_r.ack) begin
      st_nxt.ack  = 1'b1;
      st_nxt.stop = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pwr_down_ack = st_r.ack;
  assign pd_seen      = st_r.seen;
  assign stop_new     = st_r.stop;

endmodule

// >>> hdl/psb_ctrl.sv
// Purpose: User-side controller for the power-down and interrupt sideband of an endpoint core
// Assumes: AHB-Lite slave, zero wait states, OKAY always; core pins synchronous to hclk
// Notes:   MSI-X is left to the transmit stream path; requests are refused when MSI-X is on and MSI is off
//
// Summary of operation
// - We finish the packet in flight, start none, then acknowledge.
// - After acknowledging we never resume traffic.
// - Endpoint with user config space: no new requests while not in D0.
// - Root port: refrain from new requests while not in D0.
// - Enable and disable bits are set only by the root complex.
// - Core makes only legacy and MSI; MSI-X is built by user logic.
// - Legacy request raises request and pending; core pulses sent.
// - Drop the request one cycle after the sent pulse.
// - Keep request high until the first sent pulse.
// - Keep pending high until the interrupt is serviced.
`timescale 1ns/1ps
module psb_ctrl #(
  parameter int VEC_W = 32
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Core power management
  input  wire logic              turn_off_notice,
  input  wire logic [2:0]        function_power_state,
  output logic                   pwr_down_ack,
  // Core interrupt
  input  wire logic              msi_enable,
  input  wire logic              msix_enable,
  input  wire logic              intx_enable,
  input  wire logic              irq_sent,
  input  wire logic              msi_sent,
  output logic                   irq_int,
  output logic                   irq_pending,
  output logic [VEC_W-1:0]       msi_int,
  // User datapath
  input  wire logic              pkt_busy,
  output logic                   req_allow
);

  typedef struct packed {
    logic                          dp_wr;
    logic                          dp_rd;
    logic [7:0]                    dp_ofs;
    logic [31:0]                   rdata;
    logic                          auto_ack;
    logic [4:0]                    vector;
    logic                          irq_go;
    logic                          sw_ack;
    logic                          pending;
    logic                          refused;
    logic                          irq_int;
    logic [VEC_W-1:0]              msi_int;
    logic                          allow;
    psb_pkg::psb_irq_state_type    state;
  } psb_ctrl_type;

  psb_ctrl_type st_r;
  psb_ctrl_type st_nxt;

  logic pd_seen;
  logic stop_new;
  logic pwr_ack_w;

  psb_pwr_hs u_pwr (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .turn_off_notice (turn_off_notice),
    .pwr_down_ack    (pwr_ack_w),
    .pkt_busy        (pkt_busy),
    .auto_ack        (st_r.auto_ack),
    .sw_ack          (st_r.sw_ack),
    .pd_seen         (pd_seen),
    .stop_new        (stop_new)
  );

  // Status word from live core pins and our own state
  function automatic logic [31:0] status_word(input psb_ctrl_type s, input logic seen,
                                              input logic comm);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[psb_pkg::ST_MSI_EN]    = msi_enable;
    w[psb_pkg::ST_MSIX_EN]   = msix_enable;
    w[psb_pkg::ST_INTX_EN]   = intx_enable;
    w[psb_pkg::ST_PD_SEEN]   = seen;
    w[psb_pkg::ST_COMMITTED] = comm;
    w[psb_pkg::ST_IRQ_BUSY]  = (s.state != psb_pkg::IRQ_IDLE);
    w[psb_pkg::ST_PENDING]   = s.pending;
    w[psb_pkg::ST_REFUSED]   = s.refused;
    w[psb_pkg::ST_REQ_ALLOW] = s.allow;
    w[psb_pkg::ST_PSTATE_LO +: 3] = function_power_state;
    return w;
  endfunction

  logic addr_ok;
  logic wr_go;
  logic clr_pend;
  logic clr_ref;
  logic [VEC_W-1:0] vec_onehot;

  always_comb begin
    st_nxt     = st_r;
    addr_ok    = hsel && hready && htrans[1];
    wr_go      = 1'b0;
    clr_pend   = 1'b0;
    clr_ref    = 1'b0;
    vec_onehot = '0;
    vec_onehot[st_r.vector] = 1'b1;

    // Address phase capture; only whole-word transfers are expected
    st_nxt.dp_wr  = addr_ok && hwrite;
    st_nxt.dp_rd  = addr_ok && !hwrite;
    st_nxt.dp_ofs = haddr[7:0];
    st_nxt.sw_ack = 1'b0;

    // Read data registered in the address phase, ready for the data phase
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        psb_pkg::OFS_CTRL: begin
          st_nxt.rdata = {29'h0, 1'b0, st_r.auto_ack, 1'b0};
        end
        psb_pkg::OFS_STATUS: begin
          st_nxt.rdata = status_word(st_r, pd_seen, pwr_ack_w);
        end
        psb_pkg::OFS_VECTOR: begin
          st_nxt.rdata = {27'h0, st_r.vector};
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Data phase write
    if (st_r.dp_wr) begin
      unique case (st_r.dp_ofs)
        psb_pkg::OFS_CTRL: begin
          st_nxt.auto_ack = hwdata[psb_pkg::CTRL_AUTO_ACK];
          st_nxt.sw_ack   = hwdata[psb_pkg::CTRL_SW_ACK];
          wr_go           = hwdata[psb_pkg::CTRL_IRQ_GO];
        end
        psb_pkg::OFS_VECTOR: begin
          st_nxt.vector = hwdata[4:0];
        end
        psb_pkg::OFS_CLEAR: begin
          clr_pend = hwdata[psb_pkg::CLR_PENDING];
          clr_ref  = hwdata[psb_pkg::CLR_REFUSED];
        end
        default: begin
        end
      endcase
    end
    if (wr_go) begin
      st_nxt.irq_go = 1'b1;
    end

    // New requests only in D0 and before power-down
    // Live notice blocks at once, so no request slips out the cycle after it
    st_nxt.allow = (function_power_state == psb_pkg::PSTATE_D0) && !stop_new
                   && !turn_off_notice;

    if (clr_ref) begin
      st_nxt.refused = 1'b0;
    end
    // Serviced: software clears pending
    if (clr_pend) begin
      st_nxt.pending = 1'b0;
    end

    unique case (st_r.state)
      psb_pkg::IRQ_IDLE: begin
        if (st_r.irq_go) begin
          st_nxt.irq_go = wr_go;
          if (stop_new) begin
            // Powering down: no new interrupt traffic
            st_nxt.refused = 1'b1;
          end else if (msi_enable) begin
            // MSI wins even with MSI-X also set
            st_nxt.msi_int = vec_onehot;
            st_nxt.state   = psb_pkg::IRQ_MSI;
          end else if (msix_enable) begin
            // Internal controller cannot make MSI-X
            st_nxt.refused = 1'b1;
          end else if (!intx_enable) begin
            st_nxt.refused = 1'b1;
          end else begin
            st_nxt.irq_int = 1'b1;
            st_nxt.pending = 1'b1;
            st_nxt.state   = psb_pkg::IRQ_ASSERT;
          end
        end
      end
      psb_pkg::IRQ_ASSERT: begin
        // Held until the first sent pulse
        if (irq_sent) begin
          st_nxt.irq_int = 1'b0;
          st_nxt.state   = psb_pkg::IRQ_DROP;
        end
      end
      psb_pkg::IRQ_DROP: begin
        // Second pulse confirms the deassert message
        if (irq_sent) begin
          st_nxt.state = psb_pkg::IRQ_DONE;
        end
      end
      psb_pkg::IRQ_MSI: begin
        if (msi_sent) begin
          st_nxt.msi_int = '0;
          st_nxt.state   = psb_pkg::IRQ_DONE;
        end
      end
      psb_pkg::IRQ_DONE: begin
        st_nxt.state = psb_pkg::IRQ_IDLE;
      end
    endcase

    // Refusal set wins over a clear in the same cycle
    if (clr_ref && st_nxt.refused && !st_r.refused) begin
      st_nxt.refused = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r          <= '0;
      st_r.auto_ack <= psb_pkg::AUTO_ACK_RST;
      st_r.vector   <= psb_pkg::VECTOR_RST;
      st_r.state    <= psb_pkg::IRQ_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata      = st_r.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign pwr_down_ack = pwr_ack_w;
  assign irq_int     = st_r.irq_int;
  assign irq_pending = st_r.pending;
  assign msi_int     = st_r.msi_int;
  assign req_allow   = st_r.allow;

endmodule

// >>> tb/psb_ctrl_asserts.sv
// Purpose: Port checks of the sideband controller
// Assumes: One clock domain
// Notes:   Bound into psb_ctrl
`timescale 1ns/1ps
module psb_ctrl_asserts (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Power management
  input wire logic       turn_off_notice,
  input wire logic [2:0] function_power_state,
  input wire logic       pwr_down_ack,
  input wire logic       pkt_busy,
  input wire logic       req_allow,
  // Interrupt
  input wire logic       irq_sent,
  input wire logic       irq_int,
  input wire logic       irq_pending,
  input wire logic [31:0] msi_int
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_int_wait; irq_int && !irq_sent; endsequence
  sequence s_int_seen; irq_int && irq_sent; endsequence
  a_ack_rise: assert property ($rose(pwr_down_ack) |->
    $past(turn_off_notice) && !$past(pkt_busy)) else $error("ack too early");
  a_ack_hold: assert property (pwr_down_ack |=> pwr_down_ack)
    else $error("ack dropped");
  a_ack_quiet: assert property (pwr_down_ack |=> !$rose(irq_int))
    else $error("irq after ack");
  a_msi_quiet: assert property (pwr_down_ack |=> !$rose(|msi_int))
    else $error("msi after ack");
  a_allow_d0: assert property (req_allow |->
    $past(function_power_state) == psb_pkg::PSTATE_D0) else $error("allow outside D0");
  a_allow_off: assert property (turn_off_notice |=> !req_allow)
    else $error("allow after notice");
  a_int_pend: assert property (irq_int |-> irq_pending)
    else $error("irq without pending");
  a_int_hold: assert property (s_int_wait |=> irq_int)
    else $error("irq dropped early");
  a_int_drop: assert property (s_int_seen |=> !irq_int)
    else $error("irq not dropped");
endmodule

bind psb_ctrl psb_ctrl_asserts u_psb_ctrl_asserts (.hclk, .hresetn, .turn_off_notice,
  .function_power_state, .pwr_down_ack, .pkt_busy, .req_allow, .irq_sent, .irq_int,
  .irq_pending, .msi_int);

// >>> tb/psb_core_model.sv
// Purpose: Behavioural model of the endpoint core sideband
// Assumes: Answers after dly waiting cycles
// Notes:   Enables come from the bench, as the root complex owns them
`timescale 1ns/1ps
module psb_core_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench control
  input  wire logic        pd_go,
  input  wire logic [2:0]  dly,
  // Controller side
  input  wire logic        pwr_down_ack,
  input  wire logic        irq_int,
  input  wire logic [31:0] msi_int,
  output logic             turn_off_notice,
  output logic             irq_sent,
  output logic             msi_sent
);
  logic [1:0] ph;
  logic [2:0] cnt;
  wire        want = ph == 2'h0 ? irq_int || |msi_int : ph == 2'h1 && !irq_int;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {turn_off_notice, irq_sent, msi_sent, ph, cnt} <= '0;
    end else begin
      irq_sent <= 1'b0;
      msi_sent <= 1'b0;
      cnt <= want ? cnt + 3'h1 : 3'h0;
      if (pd_go) turn_off_notice <= 1'b1;
      if (pwr_down_ack) turn_off_notice <= 1'b0;
      if (want && cnt >= dly) begin
        cnt <= 3'h0;
        if (ph == 2'h0 && |msi_int) begin
          msi_sent <= 1'b1;
          ph <= 2'h2;
        end else begin
          irq_sent <= 1'b1;
          ph <= ph ^ 2'h1;
        end
      end
      // Wait for the vector to clear, else one write would be answered twice
      if (ph == 2'h2 && !(|msi_int)) ph <= 2'h0;
    end
  end
endmodule

// >>> tb/psb_ctrl_test.sv
// Purpose: Self-checking bench for psb_ctrl
// Assumes: Core model answers after a random delay
// Notes:   Read results are queued and checked in the data phase
`timescale 1ns/1ps
module psb_ctrl_test;
  logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout, rd_ph, pd_go, pkt_busy;
  logic        turn_off_notice, pwr_down_ack, msi_enable, msix_enable, intx_enable;
  logic        irq_sent, msi_sent, irq_int, irq_pending, req_allow;
  logic [31:0] haddr, hwdata, hrdata, msi_int, r;
  logic [2:0]  hsize, function_power_state, dly, m;
  logic [1:0]  htrans;
  logic [63:0] q[$];
  int          bad_count, n_compared, cyc, nl, nm, v;

  psb_ctrl u_psb_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .turn_off_notice, .function_power_state,
    .pwr_down_ack, .msi_enable, .msix_enable, .intx_enable, .irq_sent, .msi_sent, .irq_int,
    .irq_pending, .msi_int, .pkt_busy, .req_allow);
  psb_core_model u_psb_core_model (.hclk, .hresetn, .pd_go, .dly, .pwr_down_ack, .irq_int,
    .msi_int, .turn_off_notice, .irq_sent, .msi_sent);

  always #5 hclk = ~hclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Single word transfer; a read queues its masked expectation
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] mk, input logic [31:0] e);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !wr;
    if (!wr) q.push_back({mk, e & mk});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic run(input int n);
    repeat (n) begin
      @(posedge hclk);
      nl += irq_sent;
      nm += msi_sent;
      if (irq_int === 1'b1) chk(irq_pending, 1);
      if (msi_sent === 1'b1) chk(msi_int, 32'h1 << v);
    end
  endtask

  task automatic pd_pulse;
    pd_go <= 1'b1;
    @(posedge hclk);
    pd_go <= 1'b0;
  endtask

  always @(posedge hclk) begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
      chk(hrdata & q[0][63:32], q[0][31:0]);
      void'(q.pop_front());
    end
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    {hclk, hresetn, hsel, hwrite, rd_ph, pd_go, pkt_busy, msi_enable, msix_enable} = '0;
    {haddr, hwdata, htrans, function_power_state, dly, intx_enable} = '0;
    {bad_count, n_compared, cyc} = '0;
    hsize = 3'h2;
    void'($urandom(46));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    ahb(0, 8'h00, 0, 32'h6, 0);
    ahb(1, 8'h10, 32'hffff_ffff, 0, 0);
    ahb(0, 8'h10, 0, 32'hffff_ffff, 0);
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      m = r[5:3] & {3{i[0]}};
      {intx_enable, msix_enable, msi_enable} <= r[2:0];
      function_power_state <= m;
      @(posedge hclk);
      ahb(0, 8'h04, 0, 32'h7107, {17'h0, m, 3'h0, m == 3'h0, 5'h0, r[2:0]});
      chk(req_allow, m == 3'h0);
    end
    function_power_state <= 3'h0;
    // Modes: legacy, MSI-X and legacy, MSI, both, blocked, MSI only
    for (int i = 0; i < 6; i++) begin
      m = 3'(18'b001_000_011_101_110_100 >> (3 * i));
      {intx_enable, msix_enable, msi_enable} <= m;
      dly <= 3'($urandom);
      v = $urandom_range(31);
      nl = 0;
      nm = 0;
      ahb(1, 8'h08, v, 0, 0);
      ahb(0, 8'h08, 0, 32'h1f, v);
      ahb(1, 8'h00, 1, 0, 0);
      if (i == 0) ahb(1, 8'h00, 1, 0, 0);
      run(90);
      chk(nl, i == 0 ? 4 : 0);
      chk(nm, m[0]);
      ahb(0, 8'h04, 0, 32'hc0, {m != 3'h4 && !m[0], i == 0, 6'h0});
      ahb(1, 8'h0c, 3, 0, 0);
      ahb(0, 8'h04, 0, 32'hc0, 0);
    end
    pkt_busy <= 1'b1;
    pd_pulse();
    run(6);
    chk({turn_off_notice, pwr_down_ack, req_allow}, 3'h4);
    pkt_busy <= 1'b0;
    ahb(0, 8'h04, 0, 32'h118, 32'h8);
    ahb(1, 8'h00, 4, 0, 0);
    run(4);
    chk({turn_off_notice, pwr_down_ack}, 2'h1);
    nl = 0;
    nm = 0;
    ahb(1, 8'h00, 1, 0, 0);
    run(30);
    chk(nl + nm, 0);
    ahb(0, 8'h04, 0, 32'h118, 32'h18);
    // Second reset: automatic acknowledge must still wait for the packet
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(pwr_down_ack, 0);
    ahb(1, 8'h00, 2, 0, 0);
    ahb(0, 8'h00, 0, 32'h2, 32'h2);
    pkt_busy <= 1'b1;
    pd_pulse();
    run(5);
    chk(pwr_down_ack, 0);
    pkt_busy <= 1'b0;
    run(3);
    chk(pwr_down_ack, 1);
    end_of_test();
  end
endmodule
